// File: include/nvmac_map.vh
`ifndef NVMAC_MAP_VH
`define NVMAC_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define NVMAC_OFS_CTRL      6'h1F
`define NVMAC_OFS_ADDR_LOW  6'h21
`define NVMAC_OFS_ADDR_HIGH 6'h22
`define NVMAC_OFS_DATA      6'h20

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define NVMAC_BIT_READ      0
`define NVMAC_BIT_STROBE    1
`define NVMAC_BIT_ARM       2
`define NVMAC_BIT_RDYIE     3
`define NVMAC_BIT_ACT_LO    4
`define NVMAC_BIT_ACT_HI    5

// ----------------------------------------
// Action codes and reset values
// ----------------------------------------
`define NVMAC_ACT_ATOMIC    2'h0
`define NVMAC_ACT_ERASE     2'h1
`define NVMAC_ACT_WRITE     2'h2
`define NVMAC_ACT_RESET     2'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define NVMAC_ARM_CYCLES    3'h4
`define NVMAC_PROG_STALL    3'h2
`define NVMAC_READ_STALL    3'h4
`define NVMAC_WRITE_US      4500
`define NVMAC_ERASE_US      8500
`define NVMAC_OSC_KHZ       1000

`endif

// File: logic/nvmac_array.v
`timescale 1ns/1ps
// ----------------------------------------
// Byte array with registered read data
// ----------------------------------------
module nvmac_array #(
    parameter AW = 12
) (
    input  wire          clk_sys,
    input  wire          rdEn,
    input  wire          wrEn,
    input  wire [AW-1:0] addr,
    input  wire [7:0]    wrData,
    output reg  [7:0]    rdData
);
    reg [7:0] mem [0:(1<<AW)-1];

    // Read data registered, write on strobe
    always @(posedge clk_sys)
    begin
        if (wrEn)
            mem[addr] <= wrData;
        if (rdEn)
            rdData <= mem[addr];
    end
endmodule

// File: logic/nvmac_controller.v
`timescale 1ns/1ps
`include "nvmac_map.vh"
// ----------------------------------------
// Nonvolatile byte store access controller
// ----------------------------------------
module nvmac_controller #(
    parameter AW          = 12,
    parameter WRITE_TICKS = 32'd4500,
    parameter ERASE_TICKS = 32'd8500
) (
    input  wire       clk_sys,
    input  wire       resetn,
    input  wire       oscTick,
    input  wire       globalIrqEnable,
    input  wire       flashSelfprogBusy,
    input  wire       ioWrite,
    input  wire       ioRead,
    input  wire [5:0] ioAddr,
    input  wire [7:0] ioWrData,
    output reg  [7:0] ioRdData,
    output reg        cpuStall,
    output reg        readyIrq
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    localparam ST_IDLE  = 2'h0;
    localparam ST_ERASE = 2'h1;
    localparam ST_WRITE = 2'h2;

    reg  [1:0]    state_q;
    reg  [1:0]    action_q;
    reg           rdyIe_q;
    reg           arm_q;
    reg  [2:0]    armCnt_q;
    reg  [AW-1:0] addr_q;
    reg  [7:0]    data_q;
    reg  [31:0]   tick_q;
    reg  [2:0]    stall_q;
    reg           rdPend_q;
    reg           erasePh_q;
    reg           busy;
    wire [7:0]    arrRd;

    // Busy decode by case, so an unset state before the first reset reads idle
    // and the reset branches below can still clear it
    always @*
    begin
        case (state_q)
            ST_ERASE: busy = 1'b1;
            ST_WRITE: busy = 1'b1;
            default:  busy = 1'b0;
        endcase
    end

    wire wrCtrl   = ioWrite && (ioAddr == `NVMAC_OFS_CTRL);
    wire wrLow    = ioWrite && (ioAddr == `NVMAC_OFS_ADDR_LOW);
    wire wrHigh   = ioWrite && (ioAddr == `NVMAC_OFS_ADDR_HIGH);
    wire wrData   = ioWrite && (ioAddr == `NVMAC_OFS_DATA);
    wire armSet   = wrCtrl && ioWrData[`NVMAC_BIT_ARM] && !ioWrData[`NVMAC_BIT_STROBE];
    wire stbSet   = wrCtrl && ioWrData[`NVMAC_BIT_STROBE];
    // Strobe accepted only with arm live, idle, no flash activity
    wire progGo   = stbSet && arm_q && !busy && !flashSelfprogBusy;
    wire readGo   = wrCtrl && ioWrData[`NVMAC_BIT_READ] && !busy && !stbSet;
    wire erasing  = (state_q == ST_ERASE);
    wire writing  = (state_q == ST_WRITE);
    wire tickDone = oscTick && (tick_q == 32'd1);

    // Tick budget per phase; atomic runs erase then write
    function [31:0] phaseTicks;
        input isErase;
        begin
            phaseTicks = isErase ? ERASE_TICKS : WRITE_TICKS;
        end
    endfunction

    // ----------------------------------------
    // Array instance
    // ----------------------------------------
    nvmac_array #(.AW(AW)) uArray (
        .clk_sys (clk_sys),
        .rdEn    (readGo),
        .wrEn    ((writing || erasing) && tickDone),
        .addr    (addr_q),
        .wrData  (erasing ? 8'hFF : data_q),
        .rdData  (arrRd)
    );

    // ----------------------------------------
    // Programming sequencer; survives reset
    // ----------------------------------------
    // Reset is deliberately not applied here so a started
    // operation completes; only the idle case is cleared.
    always @(posedge clk_sys)
    begin
        if (!resetn && !busy)
        begin
            state_q   <= ST_IDLE;
            tick_q    <= 32'h0;
            erasePh_q <= 1'b0;
        end
        else if (progGo)
        begin
            case (action_q)
                `NVMAC_ACT_ATOMIC:
                begin
                    state_q   <= ST_ERASE;
                    tick_q    <= phaseTicks(1'b1);
                    erasePh_q <= 1'b1;
                end
                `NVMAC_ACT_ERASE:
                begin
                    state_q   <= ST_ERASE;
                    tick_q    <= phaseTicks(1'b1);
                    erasePh_q <= 1'b0;
                end
                `NVMAC_ACT_WRITE:
                begin
                    state_q   <= ST_WRITE;
                    tick_q    <= phaseTicks(1'b0);
                    erasePh_q <= 1'b0;
                end
                default:
                begin
                    state_q   <= ST_IDLE; // Reserved code starts nothing
                    tick_q    <= 32'h0;
                    erasePh_q <= 1'b0;
                end
            endcase
        end
        else if (busy && oscTick)
        begin
            if (tick_q > 32'd1)
                tick_q <= tick_q - 32'd1;
            else if (erasing && erasePh_q)
            begin
                state_q   <= ST_WRITE;
                tick_q    <= phaseTicks(1'b0);
                erasePh_q <= 1'b0;
            end
            else
            begin
                state_q <= ST_IDLE;
                tick_q  <= 32'h0;
            end
        end
    end

    // ----------------------------------------
    // Action field: frozen while busy
    // ----------------------------------------
    always @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            if (!busy)
                action_q <= `NVMAC_ACT_RESET;
        end
        else if (wrCtrl && !busy)
            action_q <= ioWrData[`NVMAC_BIT_ACT_HI:`NVMAC_BIT_ACT_LO];
    end

    // ----------------------------------------
    // Arm window, interrupt enable
    // ----------------------------------------
    always @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            arm_q    <= 1'b0;
            armCnt_q <= 3'h0;
            rdyIe_q  <= 1'b0;
        end
        else
        begin
            if (wrCtrl)
                rdyIe_q <= ioWrData[`NVMAC_BIT_RDYIE];
            if (armSet)
            begin
                arm_q    <= 1'b1;
                armCnt_q <= `NVMAC_ARM_CYCLES;
            end
            else if (progGo)
                arm_q <= 1'b0;
            else if (arm_q)
            begin
                if (armCnt_q == 3'h1)
                    arm_q <= 1'b0;
                armCnt_q <= armCnt_q - 3'h1;
            end
        end
    end

    // ----------------------------------------
    // Address and data registers
    // ----------------------------------------
    // Address reset value is left undefined on purpose.
    always @(posedge clk_sys)
    begin
        if (wrLow && !busy)
            addr_q[7:0] <= ioWrData;
        if (wrHigh && !busy)
            addr_q[AW-1:8] <= ioWrData[AW-9:0];
        if (rdPend_q)
            data_q <= arrRd;
        else if (wrData)
            data_q <= ioWrData;
    end

    // ----------------------------------------
    // CPU stall counter and read pending
    // ----------------------------------------
    always @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            stall_q  <= 3'h0;
            rdPend_q <= 1'b0;
            cpuStall <= 1'b0;
        end
        else
        begin
            rdPend_q <= readGo;
            if (progGo)
            begin
                stall_q  <= `NVMAC_PROG_STALL - 3'h1;
                cpuStall <= 1'b1;
            end
            else if (readGo)
            begin
                stall_q  <= `NVMAC_READ_STALL - 3'h1;
                cpuStall <= 1'b1;
            end
            else if (stall_q != 3'h0)
            begin
                stall_q  <= stall_q - 3'h1;
                cpuStall <= 1'b1;
            end
            else
                cpuStall <= 1'b0;
        end
    end

    // ----------------------------------------
    // Read mux and ready interrupt
    // ----------------------------------------
    always @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            ioRdData <= 8'h00;
            readyIrq <= 1'b0;
        end
        else
        begin
            readyIrq <= rdyIe_q && globalIrqEnable && !busy && !progGo;
            if (ioRead)
            begin
                case (ioAddr)
                    `NVMAC_OFS_CTRL:
                        ioRdData <= {2'h0, action_q, rdyIe_q, arm_q, busy, 1'b0};
                    `NVMAC_OFS_ADDR_LOW:
                        ioRdData <= addr_q[7:0];
                    `NVMAC_OFS_ADDR_HIGH:
                        ioRdData <= {4'h0, addr_q[AW-1:8]};
                    `NVMAC_OFS_DATA:
                        ioRdData <= rdPend_q ? arrRd : data_q;
                    default:
                        ioRdData <= 8'h00;
                endcase
            end
        end
    end
endmodule

// File: verif/nvmac_cpu_model.sv
`timescale 1ns/1ps
// ------------------------
// CPU side of the I/O bus
// ------------------------
module nvmac_cpu_model (
    input  wire       clk_sys,
    input  wire       cpuStall,
    output reg        ioWrite,
    output reg        ioRead,
    output reg  [5:0] ioAddr,
    output reg  [7:0] ioWrData
);
    initial {ioWrite, ioRead, ioAddr, ioWrData} = 16'h0000;
    // One access; halts while stalled, data flips once released
    task xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
        begin
            @(posedge clk_sys);
            while (cpuStall)
                @(posedge clk_sys);
            ioWrite  <= w;
            ioRead   <= !w;
            ioAddr   <= a;
            ioWrData <= d;
            @(posedge clk_sys);
            ioWrite  <= 1'b0;
            ioRead   <= 1'b0;
            ioWrData <= ~d;
        end
    endtask
endmodule

// File: verif/nvmac_controller_chk.sv
`timescale 1ns/1ps
// ------------------------
// Port checker
// ------------------------
module nvmac_controller_chk (
    input wire       clk_sys,
    input wire       resetn,
    input wire       oscTick,
    input wire       globalIrqEnable,
    input wire       flashSelfprogBusy,
    input wire       ioWrite,
    input wire       ioRead,
    input wire [5:0] ioAddr,
    input wire [7:0] ioWrData,
    input wire [7:0] ioRdData,
    input wire       cpuStall,
    input wire       readyIrq
);
    logic       wrCtrl;
    logic [2:0] armCnt_q;
    logic [1:0] lastAct_q;
    assign wrCtrl = ioWrite && ioAddr == 6'h1F;
    // Action of the previous control write; a reserved code starts nothing
    always @(posedge clk_sys)
    begin
        if (wrCtrl)
            lastAct_q <= ioWrData[5:4];
    end
    // Arm window shadow; strobe writes left alone to avoid false alarms
    always @(posedge clk_sys)
    begin
        if (!resetn)
            armCnt_q <= 3'h0;
        else if (wrCtrl && ioWrData[2] && !ioWrData[1])
            armCnt_q <= 3'h4;
        else if (armCnt_q != 3'h0)
            armCnt_q <= armCnt_q - 3'h1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence s_read_go;
        wrCtrl && ioWrData[0] && !ioWrData[1] ##1 cpuStall;
    endsequence
    sequence s_prog_go;
        wrCtrl && ioWrData[1] ##1 cpuStall;
    endsequence
    a_read_stall: assert property (s_read_go |-> cpuStall[*4] ##1 !cpuStall)
        else $error("read stall length");
    a_prog_stall: assert property (s_prog_go |-> cpuStall[*2] ##1 !cpuStall)
        else $error("program stall length");
    a_arm_gate: assert property (wrCtrl && ioWrData[1] && armCnt_q == 3'h0 |=> !cpuStall)
        else $error("strobe taken unarmed");
    a_arm_expire: assert property (ioRead && ioAddr == 6'h1F && armCnt_q == 3'h0 |=> !ioRdData[2])
        else $error("arm still set");
    a_flash_gate: assert property (wrCtrl && ioWrData[1] && flashSelfprogBusy |=> !cpuStall)
        else $error("start during flash busy");
    a_irq_global: assert property (!globalIrqEnable |=> !readyIrq)
        else $error("irq without global flag");
    a_irq_busy: assert property ((lastAct_q != 2'h3) ##0 s_prog_go |-> ##2 !readyIrq)
        else $error("irq while busy");
    a_addr_high: assert property (ioRead && ioAddr == 6'h22 |=> ioRdData[7:4] == 4'h0)
        else $error("address high bits nonzero");
endmodule
bind nvmac_controller nvmac_controller_chk chk (.clk_sys(clk_sys), .resetn(resetn), .oscTick(oscTick),
    .globalIrqEnable(globalIrqEnable), .flashSelfprogBusy(flashSelfprogBusy), .ioWrite(ioWrite),
    .ioRead(ioRead), .ioAddr(ioAddr), .ioWrData(ioWrData), .ioRdData(ioRdData), .cpuStall(cpuStall),
    .readyIrq(readyIrq));

// File: verif/eeprom_access_controller_bench.sv
`timescale 1ns/1ps
module eeprom_access_controller_bench;
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic        oscTick = 1'b0;
    logic        globalIrqEnable = 1'b0;
    logic        flashSelfprogBusy = 1'b0;
    logic        rdV = 1'b0;
    logic        progSeq = 1'b0;
    logic        irqOn = 1'b0;
    logic        ioWrite, ioRead, cpuStall, readyIrq;
    logic [5:0]  ioAddr;
    logic [7:0]  ioWrData, ioRdData, d;
    logic [1:0]  acts [3] = '{2'h1, 2'h2, 2'h0};
    logic [15:0] noteQ[$];
    int          miscompares = 0;
    int          n_checks = 0;
    always #50 clk_sys = ~clk_sys;
    // Short op times, yet long enough that busy outlasts the checks that follow a start
    nvmac_controller #(.WRITE_TICKS(32'd12), .ERASE_TICKS(32'd16)) uut (.clk_sys(clk_sys), .resetn(resetn),
        .oscTick(oscTick), .globalIrqEnable(globalIrqEnable), .flashSelfprogBusy(flashSelfprogBusy),
        .ioWrite(ioWrite), .ioRead(ioRead), .ioAddr(ioAddr), .ioWrData(ioWrData), .ioRdData(ioRdData),
        .cpuStall(cpuStall), .readyIrq(readyIrq));
    nvmac_cpu_model cpu (.clk_sys(clk_sys), .cpuStall(cpuStall), .ioWrite(ioWrite), .ioRead(ioRead),
        .ioAddr(ioAddr), .ioWrData(ioWrData));
    // Slow oscillator ticks and a wandering global flag
    always @(posedge clk_sys)
    begin
        oscTick         <= ($urandom % 32'h3) == 32'h0;
        globalIrqEnable <= irqOn || (!progSeq && 1'($urandom));
    end
    task chk(input logic [7:0] got, input logic [15:0] n);
        begin
            if (n[7:0] != 8'h00)
            begin
                n_checks++;
                if ((got & n[7:0]) !== n[15:8])
                begin
                    miscompares++;
                    $display("ERROR %0t got %h want %h mask %h", $time, got, n[15:8], n[7:0]);
                end
            end
        end
    endtask
    // Read results land one cycle after the read is taken
    always @(posedge clk_sys)
    begin
        if (rdV)
            chk(ioRdData, noteQ.pop_front());
        rdV <= ioRead;
    end
    task rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m);
        begin
            noteQ.push_back({e & m, m});
            cpu.xfer(1'b0, a, 8'h00);
        end
    endtask
    // Poll busy without noting a result; bound counted as a check
    task waitIdle;
        int k;
        begin
            for (k = 0; k < 99; k++)
            begin
                rd(6'h1F, 8'h00, 8'h00);
                @(negedge clk_sys);
                if (ioRdData[1] === 1'b0)
                    break;
            end
            chk({7'h00, k == 99}, 16'h0001);
        end
    endtask
    task prog(input logic [1:0] act, input int gap);
        begin
            progSeq <= 1'b1;
            cpu.xfer(1'b1, 6'h1F, {2'h0, act, 4'hC});
            repeat (gap) @(posedge clk_sys);
            cpu.xfer(1'b1, 6'h1F, {2'h0, act, 4'hA});
            progSeq <= 1'b0;
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d miscompares %0d", n_checks, miscompares);
            if (miscompares == 0 && n_checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    // Main sequence
    initial
    begin
        void'($urandom(32'h2DA7));
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(6'h1F, 8'h00, 8'hFF);
        cpu.xfer(1'b1, 6'h22, 8'hF1);
        cpu.xfer(1'b1, 6'h21, 8'hA3);
        rd(6'h22, 8'h01, 8'hFF);
        prog(2'h2, 3);
        rd(6'h1F, 8'h00, 8'h06);
        prog(2'h3, 0);
        rd(6'h1F, 8'h00, 8'h02);
        flashSelfprogBusy <= 1'b1;
        prog(2'h2, 0);
        rd(6'h1F, 8'h00, 8'h02);
        flashSelfprogBusy <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            d = 8'($urandom);
            cpu.xfer(1'b1, 6'h20, d);
            prog(acts[i], 0);
            rd(6'h1F, {2'h0, acts[i], 4'h2}, 8'h36);
            cpu.xfer(1'b1, 6'h21, 8'h00);
            cpu.xfer(1'b1, 6'h1F, 8'h31);
            rd(6'h1F, {2'h0, acts[i], 4'h2}, 8'h32);
            rd(6'h20, d, 8'hFF);
            if (i == 0)
            begin
                resetn <= 1'b0;
                @(posedge clk_sys);
                resetn <= 1'b1;
                rd(6'h1F, 8'h12, 8'h3F);
            end
            waitIdle;
            cpu.xfer(1'b1, 6'h1F, 8'h01);
            rd(6'h20, (acts[i] == 2'h1) ? 8'hFF : d, 8'hFF);
        end
        // Idle, enable set, global flag held: request must stand
        irqOn <= 1'b1;
        cpu.xfer(1'b1, 6'h1F, 8'h08);
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({7'h00, readyIrq}, 16'h0101);
        report_and_stop;
    end
    // Watchdog
    initial
    begin
        #2000000;
        miscompares++;
        report_and_stop;
    end
endmodule
